//--- rtl/ssb_pkg.sv
// Package for the synchronous serial channel: register map, field layout,
// reset values and state encodings.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package ssb_pkg;

   // ****************************************
   // Register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ADDR_CONTROL   = 8'ha0;
   localparam logic [7:0] ADDR_STATUS    = 8'ha4;
   localparam logic [7:0] ADDR_CLEAR     = 8'ha8;
   localparam logic [7:0] ADDR_IRQ_EN    = 8'hac;
   localparam logic [7:0] ADDR_TX_BUF    = 8'hb0;
   localparam logic [7:0] ADDR_RX_BUF    = 8'hb4;
   localparam logic [7:0] ADDR_GLOBAL    = 8'hb8;

   // ****************************************
   // Field layout
   // ****************************************
   localparam int BRS_LSB          = 0;
   localparam int BRS_W            = 3;
   localparam int FLAG_DONE_BIT    = 0;
   localparam int FLAG_COLL_BIT    = 1;
   localparam int IRQ_DONE_EN_BIT  = 0;
   localparam int IRQ_COLL_EN_BIT  = 1;
   localparam int GLB_EN_BIT       = 0;
   localparam int GLB_PRIO0_BIT    = 1;
   localparam int GLB_PRIO1_BIT    = 2;
   localparam int STATUS_BUSY_BIT  = 8;
   localparam int DATA_W           = 8;

   // ****************************************
   // Reset values and counts
   // ****************************************
   localparam logic [2:0] BRS_RESET      = 3'h7;
   localparam logic [1:0] IRQ_EN_RESET   = 2'h0;
   localparam logic [2:0] GLOBAL_RESET   = 3'h0;
   localparam logic [4:0] HALF_EDGES     = 5'h10;
   localparam logic [4:0] LAST_SAMPLE    = 5'h0e;
   localparam logic [2:0] BRS_FALLBACK   = 3'h1;

   typedef enum logic {ST_IDLE, ST_RUN} ssb_state_t;

endpackage : ssb_pkg

//--- rtl/ssb_baud_div.sv
// Shift clock half-period tick generator.
// Assumes brs is stable while run is high.
`timescale 1ns/1ps
module ssb_baud_div (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       run,
   input  wire logic [2:0] baud_divide_select,
   output logic            tick
);
   logic [2:0] eff_brs;
   logic [6:0] limit;
   logic [6:0] count_r;

   // Reserved zero falls back to the fastest legal rate
   assign eff_brs = (baud_divide_select == 3'h0) ? ssb_pkg::BRS_FALLBACK : baud_divide_select;
   // Half period of 2**brs clocks gives divide factor 2*2**brs
   assign limit   = 7'((8'h01 << eff_brs) - 8'h01);
   assign tick    = run && (count_r == limit);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= 7'h00;
      end else if (!run || tick) begin
         count_r <= 7'h00;
      end else begin
         count_r <= 7'(count_r + 7'h01);
      end
   end
endmodule : ssb_baud_div

//--- rtl/ssb_channel.sv
// Synchronous serial channel: shift engine, baud selection, flags and
// interrupt gating, reached over an Avalon-MM slave with waitrequest.
// Assumes one clock, asynchronous active-high reset, and a serial peer
// sampled synchronously to clk.
//
// Operation
// - Shift clock rate is oscillator divided by two times two to the select.
// - Select values one to four give divide factors 4, 8, 16, 32.
// - Collision enable in bit 1 passes the collision flag as a request.
// - Done enable in bit 0 passes the done flag as a request.
// - Request is gated by global enable; priority comes from two priority bits.
// - Enable bits 7 to 2 are reserved; the two enables reset to zero.
// - A buffer write during a transfer sets the collision flag.
// - Done flag sets on the last sampling edge of a reception.
`timescale 1ns/1ps
module ssb_channel (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             shift_clk,
   output logic             serial_out,
   input  wire logic        serial_in,
   output logic             irq,
   output logic [1:0]       irq_priority
);

   // ****************************************
   // Declarations
   // ****************************************
   logic                     ack_r;
   logic                     wr_go;
   logic                     rd_go;
   logic                     lane0;
   logic [31:0]              readdata_r;
   logic [31:0]              readdata_nxt;

   logic [2:0]               baud_divide_select_r;
   logic [1:0]               irq_en_r;
   logic [2:0]               global_r;
   logic                     write_collision_flag_r;
   logic                     transfer_done_flag_r;
   logic [7:0]               shift_r;
   logic [7:0]               rx_buf_r;
   logic [7:0]               tx_hold_r;
   logic                     sclk_r;
   logic                     sout_r;
   logic [4:0]               edge_r;
   ssb_pkg::ssb_state_t      state_r;

   logic                     tick;
   logic                     run;
   logic                     tx_write;
   logic                     start;
   logic                     collide;
   logic                     sample_now;
   logic                     last_sample;
   logic                     finish;
   logic                     clr_done;
   logic                     clr_coll;
   logic                     req_any;

   // ****************************************
   // Bus slave
   // ****************************************
   // One wait state on every access keeps read data registered
   assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
   assign wr_go           = avs_write && ack_r;
   assign rd_go           = avs_read && !ack_r;
   assign lane0           = avs_byteenable[0];
   assign avs_readdata    = readdata_r;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= (avs_read || avs_write) && !ack_r;
      end
   end

   always_comb begin
      readdata_nxt = 32'h0000_0000;
      unique case (avs_address)
         ssb_pkg::ADDR_CONTROL: begin
            readdata_nxt[ssb_pkg::BRS_LSB +: ssb_pkg::BRS_W] = baud_divide_select_r;
         end
         ssb_pkg::ADDR_STATUS: begin
            readdata_nxt[ssb_pkg::FLAG_DONE_BIT]   = transfer_done_flag_r;
            readdata_nxt[ssb_pkg::FLAG_COLL_BIT]   = write_collision_flag_r;
            readdata_nxt[ssb_pkg::STATUS_BUSY_BIT] = (state_r == ssb_pkg::ST_RUN);
         end
         ssb_pkg::ADDR_IRQ_EN: begin
            // Reserved bits 7..2 carry no storage and read as zero
            readdata_nxt[1:0] = irq_en_r;
         end
         ssb_pkg::ADDR_TX_BUF: begin
            readdata_nxt[ssb_pkg::DATA_W-1:0] = tx_hold_r;
         end
         ssb_pkg::ADDR_RX_BUF: begin
            readdata_nxt[ssb_pkg::DATA_W-1:0] = rx_buf_r;
         end
         ssb_pkg::ADDR_GLOBAL: begin
            readdata_nxt[2:0] = global_r;
         end
         default: begin
            readdata_nxt = 32'h0000_0000;
         end
      endcase
   end

   // Read data is captured on the first request cycle and held for the master
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         readdata_r <= 32'h0000_0000;
      end else if (rd_go) begin
         readdata_r <= readdata_nxt;
      end
   end

   // ****************************************
   // Control and enable registers
   // ****************************************
   // Written at any time; a change mid-transfer is the software's hazard
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         baud_divide_select_r <= ssb_pkg::BRS_RESET;
      end else if (wr_go && lane0 && avs_address == ssb_pkg::ADDR_CONTROL) begin
         baud_divide_select_r <= avs_writedata[ssb_pkg::BRS_LSB +: ssb_pkg::BRS_W];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_en_r <= ssb_pkg::IRQ_EN_RESET;
      end else if (wr_go && lane0 && avs_address == ssb_pkg::ADDR_IRQ_EN) begin
         irq_en_r <= avs_writedata[1:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         global_r <= ssb_pkg::GLOBAL_RESET;
      end else if (wr_go && lane0 && avs_address == ssb_pkg::ADDR_GLOBAL) begin
         global_r <= avs_writedata[2:0];
      end
   end

   // ****************************************
   // Shift engine
   // ****************************************
   assign tx_write    = wr_go && lane0 && (avs_address == ssb_pkg::ADDR_TX_BUF);
   assign start       = tx_write && (state_r == ssb_pkg::ST_IDLE);
   assign collide     = tx_write && (state_r == ssb_pkg::ST_RUN);
   assign run         = (state_r == ssb_pkg::ST_RUN);
   // Even half ticks raise the shift clock and sample, odd ones shift
   assign sample_now  = tick && !edge_r[0];
   assign last_sample = tick && (edge_r == ssb_pkg::LAST_SAMPLE);
   assign finish      = tick && (edge_r == 5'(ssb_pkg::HALF_EDGES - 5'h01));

   ssb_baud_div u_div (
      .clk (clk),
      .rst (rst),
      .run (run),
      .baud_divide_select (baud_divide_select_r),
      .tick(tick)
   );

   // Frame runs from the buffer write until the sixteenth half tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_r <= ssb_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            ssb_pkg::ST_IDLE: begin
               if (start) begin
                  state_r <= ssb_pkg::ST_RUN;
               end
            end
            ssb_pkg::ST_RUN: begin
               if (finish) begin
                  state_r <= ssb_pkg::ST_IDLE;
               end
            end
         endcase
      end
   end

   // Half tick counter reloads on every start, so no count leaks between frames
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         edge_r <= 5'h00;
      end else if (start) begin
         edge_r <= 5'h00;
      end else if (tick) begin
         edge_r <= 5'(edge_r + 5'h01);
      end
   end

   // Shift clock idles low between frames
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_r <= 1'b0;
      end else if (start) begin
         sclk_r <= 1'b0;
      end else if (tick) begin
         sclk_r <= !sclk_r;
      end
   end

   // Collided writes land in the holding copy only, so the running frame survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tx_hold_r <= 8'h00;
      end else if (tx_write) begin
         tx_hold_r <= avs_writedata[ssb_pkg::DATA_W-1:0];
      end
   end

   // One register serves both ways: each sample pushes a sent bit out the top
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_r <= 8'h00;
      end else if (start) begin
         shift_r <= avs_writedata[ssb_pkg::DATA_W-1:0];
      end else if (sample_now) begin
         shift_r <= {shift_r[6:0], serial_in};
      end
   end

   // First bit is presented straight after the write, next ones on falling edges
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sout_r <= 1'b0;
      end else if (start) begin
         sout_r <= avs_writedata[ssb_pkg::DATA_W-1];
      end else if (tick && edge_r[0] && !finish) begin
         sout_r <= shift_r[7];
      end
   end

   // Receive buffer takes the byte on the last sample, before the frame ends
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rx_buf_r <= 8'h00;
      end else if (last_sample) begin
         rx_buf_r <= {shift_r[6:0], serial_in};
      end
   end

   assign shift_clk  = sclk_r;
   assign serial_out = sout_r;

   // ****************************************
   // Flags and interrupt
   // ****************************************
   // Clear register is write-only; a one clears, a zero leaves the flag alone
   assign clr_done = wr_go && lane0 && (avs_address == ssb_pkg::ADDR_CLEAR)
                     && avs_writedata[ssb_pkg::FLAG_DONE_BIT];
   assign clr_coll = wr_go && lane0 && (avs_address == ssb_pkg::ADDR_CLEAR)
                     && avs_writedata[ssb_pkg::FLAG_COLL_BIT];

   // A set in the same cycle as a clear wins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         transfer_done_flag_r <= 1'b0;
      end else if (last_sample) begin
         transfer_done_flag_r <= 1'b1;
      end else if (clr_done) begin
         transfer_done_flag_r <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         write_collision_flag_r <= 1'b0;
      end else if (collide) begin
         write_collision_flag_r <= 1'b1;
      end else if (clr_coll) begin
         write_collision_flag_r <= 1'b0;
      end
   end

   // Enables can be written while the global enable is on; nothing here holds back a glitch
   assign req_any = (write_collision_flag_r && irq_en_r[ssb_pkg::IRQ_COLL_EN_BIT])
                    || (transfer_done_flag_r && irq_en_r[ssb_pkg::IRQ_DONE_EN_BIT]);

   assign irq          = req_any && global_r[ssb_pkg::GLB_EN_BIT];
   // Priority bits only steer the arbiter outside; they never gate the request
   assign irq_priority = {global_r[ssb_pkg::GLB_PRIO1_BIT],
                          global_r[ssb_pkg::GLB_PRIO0_BIT]};

endmodule : ssb_channel

//--- verification/ssb_channel_sva.sv
// Checker for the serial channel, watching its top-level ports only.
// Assumes one clock domain; shadows the enable register, the global enable bit and the select register.
`timescale 1ns/1ps
module ssb_channel_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0]  avs_byteenable,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        shift_clk,
   input wire logic        serial_out,
   input wire logic        serial_in,
   input wire logic        irq,
   input wire logic [1:0]  irq_priority
);
   logic [1:0] en_r;
   logic       glb_r;
   logic [2:0] brs_r;
   logic [8:0] hi_r;
   logic [8:0] lo_r;
   logic       wr_ok;
   logic       txw;
   logic [8:0] half;
   assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
   assign txw   = wr_ok && (avs_address == ssb_pkg::ADDR_TX_BUF);
   assign half  = (brs_r == 3'h0) ? 9'h2 : (9'h1 << brs_r);
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         en_r  <= ssb_pkg::IRQ_EN_RESET;
         glb_r <= 1'b0;
         brs_r <= ssb_pkg::BRS_RESET;
      end else if (wr_ok) begin
         if (avs_address == ssb_pkg::ADDR_IRQ_EN) en_r <= avs_writedata[1:0];
         if (avs_address == ssb_pkg::ADDR_GLOBAL) glb_r <= avs_writedata[0];
         if (avs_address == ssb_pkg::ADDR_CONTROL) brs_r <= avs_writedata[2:0];
      end
   end
   // Low count saturates so a long idle gap cannot wrap into a false short phase
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hi_r <= 9'h0;
         lo_r <= 9'h0;
      end else begin
         hi_r <= shift_clk ? hi_r + 9'h1 : 9'h0;
         lo_r <= shift_clk ? 9'h0 : ((lo_r == 9'h1ff) ? lo_r : lo_r + 9'h1);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_irq_up;
      $rose(irq) && $stable(en_r) && $stable(glb_r);
   endsequence
   sequence s_glb_wr;
      wr_ok && (avs_address == ssb_pkg::ADDR_GLOBAL);
   endsequence
   baud_high_a: assert property ($fell(shift_clk) |-> hi_r == half)
      else $error("shift clock high phase length wrong");
   baud_low_a: assert property ($rose(shift_clk) |-> lo_r >= half)
      else $error("shift clock low phase too short");
   irq_global_a: assert property (!glb_r |-> !irq)
      else $error("request while global enable clear");
   irq_noen_a: assert property (en_r == 2'h0 |-> !irq)
      else $error("request with both enables clear");
   prio_out_a: assert property (s_glb_wr |=> irq_priority == $past(avs_writedata[2:1]))
      else $error("priority output does not follow global register");
   en_read_a: assert property (avs_read && !avs_waitrequest &&
      avs_address == ssb_pkg::ADDR_IRQ_EN |-> avs_readdata == {30'h0, en_r})
      else $error("enable register read wrong");
   coll_irq_a: assert property (s_irq_up ##0 en_r == 2'h2 |-> $past(txw))
      else $error("collision request without buffer write");
   done_irq_a: assert property (s_irq_up ##0 en_r == 2'h1 |-> ##[0:2] shift_clk)
      else $error("done request away from last sample edge");
endmodule : ssb_channel_chk
bind ssb_channel ssb_channel_chk chk_u (.clk(clk), .rst(rst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .shift_clk(shift_clk), .serial_out(serial_out),
   .serial_in(serial_in), .irq(irq), .irq_priority(irq_priority));

//--- verification/ssb_peer.sv
// Serial peer model: shifts a byte out MSB first and captures what it receives.
// Assumes shift clock idles low, data changes after falling edges.
`timescale 1ns/1ps
module ssb_peer (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       shift_clk,
   input  wire logic       serial_out,
   input  wire logic       load,
   input  wire logic [7:0] tx_byte,
   output logic            serial_in,
   output logic [7:0]      rx_byte
);
   logic       sclk_q_r;
   logic [3:0] cnt_r;
   logic [7:0] sh_r;
   // Line is inverted after a frame so a stale bit never looks valid
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sclk_q_r  <= 1'b0;
         cnt_r     <= 4'h0;
         sh_r      <= 8'h0;
         serial_in <= 1'b0;
         rx_byte   <= 8'h0;
      end else begin
         sclk_q_r <= shift_clk;
         if (load) begin
            sh_r      <= tx_byte;
            serial_in <= tx_byte[7];
            cnt_r     <= 4'h0;
         end else if (shift_clk && !sclk_q_r) begin
            rx_byte <= {rx_byte[6:0], serial_out};
            cnt_r   <= cnt_r + 4'h1;
         end else if (!shift_clk && sclk_q_r) begin
            sh_r      <= {sh_r[6:0], 1'b0};
            serial_in <= (cnt_r == 4'h8) ? !serial_in : sh_r[6];
         end
      end
   end
endmodule : ssb_peer

//--- verification/ssb_channel_tb_top.sv
// Testbench for the serial channel: register tasks over Avalon-MM and a peer.
// Assumes the checker binds itself to the design.
`timescale 1ns/1ps
module ssb_channel_tb_top;
   logic        clk, rst, avs_read, avs_write, shift_clk, serial_out, serial_in, irq, load;
   logic [7:0]  avs_address, tx_byte, rx_byte;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [3:0]  avs_byteenable;
   logic        avs_waitrequest;
   logic [1:0]  irq_priority;
   int          mismatches, num_checks;
   always #4 clk = ~clk;
   ssb_channel dut_u (.clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .shift_clk(shift_clk),
      .serial_out(serial_out), .serial_in(serial_in), .irq(irq), .irq_priority(irq_priority));
   ssb_peer peer_u (.clk(clk), .rst(rst), .shift_clk(shift_clk), .serial_out(serial_out),
      .load(load), .tx_byte(tx_byte), .serial_in(serial_in), .rx_byte(rx_byte));
   // ****************************************
   // Tasks
   // ****************************************
   task report_and_stop;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task tmo;
      mismatches++;
      $display("[ERR] %0t wait bound used up", $time);
      report_and_stop();
   endtask : tmo
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !w;
      avs_write <= w;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      if (n >= 20) tmo();
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task rdc(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdc
   task chkirq(input logic e);
      @(negedge clk);
      chk({31'h0, irq}, {31'h0, e});
   endtask : chkirq
   task xfer(input logic [2:0] b, input logic [7:0] d, input logic c);
      int n, per;
      bus(1'b1, ssb_pkg::ADDR_CONTROL, {29'h0, b});
      tx_byte <= ~d;
      load <= 1'b1;
      @(posedge clk);
      load <= 1'b0;
      bus(1'b1, ssb_pkg::ADDR_TX_BUF, {24'h0, d});
      if (c) bus(1'b1, ssb_pkg::ADDR_TX_BUF, {24'h0, ~d});
      n = 0;
      per = 0;
      while (shift_clk !== 1'b1 && n < 2000) begin @(posedge clk); n++; end
      while (shift_clk === 1'b1 && per < 2000) begin @(posedge clk); per++; end
      while (shift_clk !== 1'b1 && per < 2000) begin @(posedge clk); per++; end
      if (n >= 2000 || per >= 2000) tmo();
      chk(32'(per), 32'h2 << b);
      n = 0;
      do begin
         bus(1'b0, ssb_pkg::ADDR_STATUS, 32'h0);
         n++;
      end while (rd[8] !== 1'b0 && n < 500);
      if (n >= 500) tmo();
      chk({24'h0, rx_byte}, {24'h0, d});
      rdc(ssb_pkg::ADDR_RX_BUF, {24'h0, ~d});
   endtask : xfer
   // ****************************************
   // Sequence
   // ****************************************
   initial begin
      clk = 1'b0; rst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 8'h0;
      avs_writedata = 32'h0; avs_byteenable = 4'h1; load = 1'b0; tx_byte = 8'h0;
      mismatches = 0; num_checks = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      rdc(ssb_pkg::ADDR_CONTROL, 32'h7);
      rdc(ssb_pkg::ADDR_IRQ_EN, 32'h0);
      bus(1'b1, ssb_pkg::ADDR_IRQ_EN, 32'hff);
      rdc(ssb_pkg::ADDR_IRQ_EN, 32'h3);
      bus(1'b1, ssb_pkg::ADDR_IRQ_EN, 32'h0);
      rdc(8'hfc, 32'h0);
      for (int b = 1; b <= 4; b++) begin
         xfer(3'(b), 8'ha5 ^ 8'(b), 1'b0);
         rdc(ssb_pkg::ADDR_STATUS, 32'h1);
         bus(1'b1, ssb_pkg::ADDR_CLEAR, 32'h3);
      end
      bus(1'b1, ssb_pkg::ADDR_IRQ_EN, 32'h1);
      bus(1'b1, ssb_pkg::ADDR_GLOBAL, 32'h7);
      @(negedge clk);
      chk({30'h0, irq_priority}, 32'h3);
      rdc(ssb_pkg::ADDR_GLOBAL, 32'h7);
      xfer(3'h2, 8'h81, 1'b0);
      chkirq(1'b1);
      bus(1'b1, ssb_pkg::ADDR_GLOBAL, 32'h0);
      chkirq(1'b0);
      bus(1'b1, ssb_pkg::ADDR_IRQ_EN, 32'h2);
      bus(1'b1, ssb_pkg::ADDR_GLOBAL, 32'h1);
      chkirq(1'b0);
      xfer(3'h3, 8'h5e, 1'b1);
      rdc(ssb_pkg::ADDR_STATUS, 32'h3);
      rdc(ssb_pkg::ADDR_TX_BUF, 32'ha1);
      chkirq(1'b1);
      bus(1'b1, ssb_pkg::ADDR_CLEAR, 32'h2);
      chkirq(1'b0);
      bus(1'b1, ssb_pkg::ADDR_GLOBAL, 32'h0);
      bus(1'b1, ssb_pkg::ADDR_IRQ_EN, 32'h3);
      bus(1'b1, ssb_pkg::ADDR_GLOBAL, 32'h1);
      chkirq(1'b1);
      report_and_stop();
   end
endmodule : ssb_channel_tb_top
